// *** hw/almc_regs.svh ***
// register offsets, field positions, reset values and framing constants of the link mode block
`ifndef ALMC_REGS_SVH
`define ALMC_REGS_SVH

`define ALMC_OFS_RATE_RATIO   16'h00ca
`define ALMC_OFS_LANE0_RATE   16'h0670
`define ALMC_OFS_LANE7_RATE   16'h0677
`define ALMC_OFS_MODE_SEL     16'h0702
`define ALMC_OFS_LINK_RATE    16'h0728
`define ALMC_OFS_ASYNC        16'h0780
`define ALMC_OFS_FRAME0       16'h0790
`define ALMC_OFS_FRAME1       16'h0791
`define ALMC_OFS_STATUS       16'h0792

`define ALMC_MODE_LSB         0
`define ALMC_MODE_MSB         5
`define ALMC_SUB_LSB          6
`define ALMC_SUB_MSB          7

`define ALMC_RST_BYTE         8'h00
`define ALMC_LANES            4'h4

`endif

// *** hw/almc_pkg.sv ***
// types shared by the link mode configuration block
package almc_pkg;

    typedef struct packed {
        logic [3:0] lanes;
        logic [3:0] conv;
        logic [3:0] octets;
        logic [3:0] samples;
        logic [8:0] multiframe;
        logic [1:0] ext_mf;
        logic [4:0] res_bits;
        logic [4:0] tot_bits;
        logic       hd;
    } almc_frame_t;

    typedef enum logic [1:0] {
        ALMC_IDLE,
        ALMC_ACK
    } almc_bus_t;

endpackage

// *** hw/almc_mode_decoder.sv ***
// mode number / sub-select to framing parameter lookup
`timescale 1ns/10ps
`include "almc_regs.svh"

module almc_mode_decoder
    import almc_pkg::*;
(
    // selection
    input  wire logic [5:0]  link_mode_number,
    input  wire logic [1:0]  link_mode_subselect,
    // result
    output almc_frame_t      frame,
    output logic             supported
);

    function automatic almc_frame_t mk(input logic [3:0] m, input logic [3:0] f,
                                       input logic [3:0] s, input logic [8:0] k,
                                       input logic [1:0] e, input logic [4:0] n,
                                       input logic hd);
        almc_frame_t r;
        r.lanes      = `ALMC_LANES;
        r.conv       = m;
        r.octets     = f;
        r.samples    = s;
        r.multiframe = k;
        r.ext_mf     = e;
        r.res_bits   = n;
        r.tot_bits   = n;
        r.hd         = hd;
        return r;
    endfunction

    always_comb begin
        frame     = '0;
        supported = 1'b1;
        case ({link_mode_number, link_mode_subselect})
            {6'h0d, 2'h0}: frame = mk(4'h2, 4'h1, 4'h1, 9'h100, 2'h1, 5'h10, 1'b1);
            {6'h0d, 2'h1}: frame = mk(4'h2, 4'h2, 4'h2, 9'h080, 2'h1, 5'h10, 1'b0);
            {6'h0d, 2'h2}: frame = mk(4'h2, 4'h4, 4'h4, 9'h040, 2'h1, 5'h10, 1'b0);
            {6'h0d, 2'h3}: frame = mk(4'h2, 4'h8, 4'h8, 9'h020, 2'h1, 5'h10, 1'b0);
            {6'h0e, 2'h0}: frame = mk(4'h2, 4'h3, 4'h4, 9'h100, 2'h3, 5'h0c, 1'b0);
            {6'h0e, 2'h1}: frame = mk(4'h2, 4'h6, 4'h8, 9'h080, 2'h3, 5'h0c, 1'b0);
            {6'h0b, 2'h0}: frame = mk(4'h4, 4'h2, 4'h1, 9'h080, 2'h1, 5'h10, 1'b0);
            {6'h19, 2'h0}: frame = mk(4'h4, 4'h3, 4'h2, 9'h100, 2'h3, 5'h0c, 1'b0);
            default:       supported = 1'b0;
        endcase
    end

endmodule

// *** hw/almc_top.sv ***
// four-lane link mode configuration registers and framing decoder
//
// Contract
// - every supported or manual configuration reports four lanes; an unsupported mode reports zero
// - mode number from link_mode_select bits 5:0
// - sub-select from link_mode_select bits 7:6
// - mode 13.00 gives M2 F1 S1 K256 HD1
// - mode 13.10 gives M2 F2 S2 K128
// - mode 13.20 gives M2 F4 S4 K64
// - mode 13.30 gives M2 F8 S8 K32
// - mode 14.00 gives M2 F3 S4 E3 N12
// - mode 14.10 gives M2 F6 S8 E3 N12
// - mode 11.00 gives M4 F2 S1 K128
// - mode 25.00 gives M4 F3 S2 E3 N12
// - 13.01 written field by field, HD1
// - 13.11 written field by field
// - 13.21 written field by field
// - 14.01 field by field, asynchronous only; manual framing is taken whatever link_async_flag holds
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/10ps
`include "almc_regs.svh"

module almc_top
    import almc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // avalon-mm slave
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       avs_response,
    // framing parameters toward the link transmitter
    output logic [3:0]       link_lanes,
    output logic [3:0]       link_conv,
    output logic [3:0]       link_octets,
    output logic [3:0]       link_samples,
    output logic [8:0]       link_multiframe,
    output logic [1:0]       link_ext_mf,
    output logic [4:0]       link_res_bits,
    output logic [4:0]       link_tot_bits,
    output logic             link_hd,
    output logic             link_mode_unsupported,
    output logic             link_async_flag,
    // rate settings
    output logic [3:0]       lane_rate_sel [8],
    output logic [7:0]       link_rate,
    output logic [5:0]       rate_ratio
);

    // registers
    logic [7:0]  mode_sel_reg;
    logic [7:0]  lane_rate_reg [8];
    logic [7:0]  link_rate_reg;
    logic [7:0]  rate_ratio_reg;
    logic        async_reg;
    logic        manual_reg;
    almc_frame_t man_frame_reg;
    almc_frame_t frame_reg;
    logic        unsup_reg;
    almc_bus_t   bus_state_reg;

    logic [5:0]  link_mode_number;
    logic [1:0]  link_mode_subselect;
    almc_frame_t dec_frame;
    logic        dec_supported;
    logic        hit;
    logic        wr_take;
    logic [7:0]  wbyte;

    assign link_mode_number    = mode_sel_reg[`ALMC_MODE_MSB:`ALMC_MODE_LSB];
    assign link_mode_subselect = mode_sel_reg[`ALMC_SUB_MSB:`ALMC_SUB_LSB];
    assign wbyte               = avs_writedata[7:0];

    function automatic logic is_lane(input logic [15:0] a);
        return (a >= `ALMC_OFS_LANE0_RATE) && (a <= `ALMC_OFS_LANE7_RATE);
    endfunction

    function automatic logic decoded(input logic [15:0] a);
        return is_lane(a) || a == `ALMC_OFS_RATE_RATIO || a == `ALMC_OFS_MODE_SEL ||
               a == `ALMC_OFS_LINK_RATE || a == `ALMC_OFS_ASYNC ||
               a == `ALMC_OFS_FRAME0 || a == `ALMC_OFS_FRAME1 || a == `ALMC_OFS_STATUS;
    endfunction

    almc_mode_decoder u_dec (
        .link_mode_number    (link_mode_number),
        .link_mode_subselect (link_mode_subselect),
        .frame               (dec_frame),
        .supported           (dec_supported)
    );

    // one wait cycle per access: requests are taken in idle, acked the next cycle
    assign avs_waitrequest = (bus_state_reg != ALMC_ACK);
    assign hit     = decoded(avs_address);
    assign wr_take = (bus_state_reg == ALMC_ACK) && avs_write && avs_byteenable[0];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_state_reg <= ALMC_IDLE;
        end else if (bus_state_reg == ALMC_IDLE && (avs_read || avs_write)) begin
            bus_state_reg <= ALMC_ACK;
        end else begin
            bus_state_reg <= ALMC_IDLE;
        end
    end

    // mode select; with manual framing off, the frame only changes when this is rewritten
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_sel_reg <= `ALMC_RST_BYTE;
        end else if (wr_take && avs_address == `ALMC_OFS_MODE_SEL) begin
            mode_sel_reg <= wbyte;
        end
    end

    // per-lane rate fields, one per lane so dual links may differ
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 8; i++) begin
                lane_rate_reg[i] <= `ALMC_RST_BYTE;
            end
        end else if (wr_take && is_lane(avs_address)) begin
            lane_rate_reg[avs_address[2:0]] <= wbyte;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            link_rate_reg  <= `ALMC_RST_BYTE;
            rate_ratio_reg <= `ALMC_RST_BYTE;
            async_reg      <= 1'b0;
        end else if (wr_take) begin
            if (avs_address == `ALMC_OFS_LINK_RATE) begin
                link_rate_reg <= wbyte;
            end
            if (avs_address == `ALMC_OFS_RATE_RATIO) begin
                rate_ratio_reg <= {2'b00, wbyte[5:0]};
            end
            if (avs_address == `ALMC_OFS_ASYNC) begin
                async_reg <= wbyte[0];
            end
        end
    end

    // individual fields for configurations that have no mode code
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            manual_reg    <= 1'b0;
            man_frame_reg <= '0;
        end else if (wr_take && avs_address == `ALMC_OFS_FRAME0) begin
            manual_reg               <= avs_writedata[31];
            man_frame_reg.lanes      <= `ALMC_LANES;
            man_frame_reg.conv       <= avs_writedata[3:0];
            man_frame_reg.octets     <= avs_writedata[7:4];
            man_frame_reg.samples    <= avs_writedata[11:8];
            man_frame_reg.multiframe <= avs_writedata[20:12];
            man_frame_reg.hd         <= avs_writedata[21];
        end else if (wr_take && avs_address == `ALMC_OFS_FRAME1) begin
            man_frame_reg.ext_mf   <= avs_writedata[1:0];
            man_frame_reg.res_bits <= avs_writedata[6:2];
            man_frame_reg.tot_bits <= avs_writedata[11:7];
        end
    end

    // latched frame; held until the mode select or a manual framing word is rewritten
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_reg <= '0;
            unsup_reg <= 1'b0;
        end else if (manual_reg) begin
            frame_reg <= man_frame_reg;
            unsup_reg <= 1'b0;
        end else begin
            frame_reg <= dec_frame;
            unsup_reg <= !dec_supported;
        end
    end

    // read data; unmapped addresses answer with slaveerror and zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
            avs_response <= 2'h0;
        end else if (bus_state_reg == ALMC_IDLE && (avs_read || avs_write)) begin
            avs_response <= hit ? 2'h0 : 2'h2;
            avs_readdata <= 32'h0000_0000;
            if (avs_read) begin
                if (is_lane(avs_address)) begin
                    avs_readdata <= {24'h0, lane_rate_reg[avs_address[2:0]]};
                end else begin
                    case (avs_address)
                        `ALMC_OFS_MODE_SEL:   avs_readdata <= {24'h0, mode_sel_reg};
                        `ALMC_OFS_LINK_RATE:  avs_readdata <= {24'h0, link_rate_reg};
                        `ALMC_OFS_RATE_RATIO: avs_readdata <= {24'h0, rate_ratio_reg};
                        `ALMC_OFS_ASYNC:      avs_readdata <= {31'h0, async_reg};
                        `ALMC_OFS_FRAME0:     avs_readdata <= {manual_reg, 9'h0,
                                                               frame_reg.hd,
                                                               frame_reg.multiframe,
                                                               frame_reg.samples,
                                                               frame_reg.octets,
                                                               frame_reg.conv};
                        `ALMC_OFS_FRAME1:     avs_readdata <= {20'h0, frame_reg.tot_bits,
                                                               frame_reg.res_bits,
                                                               frame_reg.ext_mf};
                        `ALMC_OFS_STATUS:     avs_readdata <= {27'h0, frame_reg.lanes,
                                                               unsup_reg};
                        default:              avs_readdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    assign link_lanes            = frame_reg.lanes;
    assign link_conv             = frame_reg.conv;
    assign link_octets           = frame_reg.octets;
    assign link_samples          = frame_reg.samples;
    assign link_multiframe       = frame_reg.multiframe;
    assign link_ext_mf           = frame_reg.ext_mf;
    assign link_res_bits         = frame_reg.res_bits;
    assign link_tot_bits         = frame_reg.tot_bits;
    assign link_hd               = frame_reg.hd;
    assign link_mode_unsupported = unsup_reg;
    assign link_async_flag       = async_reg;
    assign link_rate             = link_rate_reg;
    assign rate_ratio            = rate_ratio_reg[5:0];

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lane_rate_sel[i] = lane_rate_reg[i][3:0];
        end
    end

endmodule

// *** verification/almc_checker.sv ***
// concurrent checks of the link mode block, seen from its ports
`timescale 1ns/10ps
module almc_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // register bus
    input wire logic [15:0] avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    // link outputs
    input wire logic [3:0]  link_lanes,
    input wire logic [3:0]  link_conv,
    input wire logic [3:0]  link_octets,
    input wire logic [8:0]  link_multiframe,
    input wire logic [1:0]  link_ext_mf,
    input wire logic [4:0]  link_res_bits,
    input wire logic        link_hd,
    input wire logic        link_mode_unsupported,
    input wire logic [3:0]  lane_rate_sel [8],
    input wire logic [7:0]  link_rate
);
    logic       wr_ack;
    logic       mode_wr;
    logic       manual_q;
    logic [7:0] wd;
    assign wr_ack  = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign mode_wr = wr_ack && avs_address == 16'h0702 && !manual_q;
    assign wd      = avs_writedata[7:0];
    // manual framing overrides the decoder, so decoder checks stand down while it is set
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            manual_q <= 1'b0;
        end else if (wr_ack && avs_address == 16'h0790) begin
            manual_q <= avs_writedata[31];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    chk_lanes_four: assert property (link_conv != 4'h0 |-> link_lanes == 4'h4)
        else $error("active frame does not report four lanes");
    chk_mode_thirteen: assert property (
        mode_wr && wd[5:0] == 6'h0d |-> ##2 link_conv == 4'h2 && link_hd == ($past(wd[7:6], 2) == 2'h0)
        && link_octets == 4'h1 << $past(wd[7:6], 2) && link_multiframe == 9'h100 >> $past(wd[7:6], 2))
        else $error("mode 13 framing wrong");
    chk_mode_fourteen: assert property (
        mode_wr && wd[5:0] == 6'h0e && !wd[7] |-> ##2 link_ext_mf == 2'h3 && link_res_bits == 5'h0c
        && link_octets == ($past(wd[6], 2) ? 4'h6 : 4'h3))
        else $error("mode 14 framing wrong");
    chk_mode_four_conv: assert property (
        mode_wr && (wd == 8'h0b || wd == 8'h19) |-> ##2 link_conv == 4'h4
        && link_multiframe == ($past(wd[4], 2) ? 9'h100 : 9'h080))
        else $error("four converter framing wrong");
    chk_unlisted_flag: assert property (
        mode_wr && ((wd[5:0] == 6'h0e && wd[7]) || wd[5:0] == 6'h3f) |-> ##2 link_mode_unsupported)
        else $error("unlisted mode not flagged");
    chk_frame_hold: assert property (
        !wr_ack && !$past(wr_ack) && $past(rst_b) |=> $stable(link_conv) && $stable(link_octets)
        && $stable(link_multiframe) && $stable(link_mode_unsupported))
        else $error("framing changed without a register write");
    chk_lane_rate_store: assert property (
        wr_ack && avs_address[15:3] == 13'h00ce |=>
        lane_rate_sel[$past(avs_address[2:0])] == $past(avs_writedata[3:0]))
        else $error("lane rate field not stored");
    chk_link_rate_store: assert property (wr_ack && avs_address == 16'h0728 |=> link_rate == $past(wd))
        else $error("link rate not stored");
    cov_manual: cover property (manual_q && link_conv == 4'h1);
    cov_unlisted: cover property (mode_wr ##2 link_mode_unsupported);
    cov_be_drop: cover property (avs_write && !avs_waitrequest && !avs_byteenable[0]);
endmodule

bind almc_top almc_checker u_chk (.*);

// *** verification/almc_rx_model.sv ***
// far-end receiver model: accepts a frame only when lane count and framing are usable
`timescale 1ns/10ps
module almc_rx_model (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // framing from the block
    input wire logic [3:0] link_lanes,
    input wire logic [3:0] link_octets,
    input wire logic       link_mode_unsupported,
    // status
    output logic           rx_ready
);
    // a four-lane receiver cannot align on any other lane count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_ready <= 1'b0;
        end else begin
            rx_ready <= link_lanes == 4'h4 && link_octets != 4'h0 && !link_mode_unsupported;
        end
    end
endmodule

// *** verification/almc_top_tb.sv ***
// self-checking bench for the four-lane link mode block
`timescale 1ns/10ps
module almc_top_tb;
    logic        clk, rst_b, avs_read, avs_write, avs_waitrequest, link_hd, rx_ready;
    logic        link_mode_unsupported, link_async_flag;
    logic [1:0]  avs_response, link_ext_mf, resp;
    logic [3:0]  avs_byteenable, link_lanes, link_conv, link_octets, link_samples;
    logic [3:0]  lane_rate_sel [8];
    logic [4:0]  link_res_bits, link_tot_bits;
    logic [5:0]  rate_ratio;
    logic [7:0]  link_rate;
    logic [8:0]  link_multiframe;
    logic [15:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [39:0] frame_now;
    logic [7:0]  bad [3] = '{8'h8e, 8'hce, 8'h3f};
    logic [7:0]  rate [3] = '{8'h11, 8'h22, 8'h33};
    int          err_count, check_count;
    assign frame_now = {1'b0, link_lanes, link_conv, link_octets, link_samples, link_multiframe,
                        link_ext_mf, link_res_bits, link_tot_bits, link_hd, link_mode_unsupported};
    almc_top dut (.*);
    almc_rx_model u_rx (.*);
    always #5 clk = ~clk;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one bus access; the slave decides when it answers, the watchdog bounds the wait
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        avs_address    <= a;
        avs_write      <= w;
        avs_read       <= !w;
        avs_writedata  <= d;
        avs_byteenable <= be;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q    = avs_readdata;
        resp = avs_response;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [39:0] fr(input int m, f, s, k, e, n, hd);
        return {5'h04, m[3:0], f[3:0], s[3:0], k[8:0], e[1:0], n[4:0], n[4:0], hd[0], 1'b0};
    endfunction
    task automatic setm(input logic [7:0] v, input logic [39:0] exp);
        acc(1'b1, 16'h0702, {24'h0, v}, 4'h1);
        @(posedge clk);
        chk(frame_now, exp);
        acc(1'b0, 16'h0702, 32'h0, 4'hf);
        chk({q, resp}, {24'h0, v, 2'h0});
        chk(rx_ready, !exp[0]);
    endtask
    // uncoded layouts go in through the manual framing words
    task automatic man(input int m, f, s, k, e, n, hd);
        acc(1'b1, 16'h0791, {20'h0, n[4:0], n[4:0], e[1:0]}, 4'hf);
        acc(1'b1, 16'h0790, {1'b1, 9'h0, hd[0], k[8:0], s[3:0], f[3:0], m[3:0]}, 4'hf);
        @(posedge clk);
        chk(frame_now, fr(m, f, s, k, e, n, hd));
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        avs_address = 16'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        err_count = 0;
        check_count = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        chk(link_mode_unsupported, 1'b1);
        setm(8'h0d, fr(2, 1, 1, 256, 1, 16, 1));
        setm(8'h4d, fr(2, 2, 2, 128, 1, 16, 0));
        setm(8'h8d, fr(2, 4, 4, 64, 1, 16, 0));
        setm(8'hcd, fr(2, 8, 8, 32, 1, 16, 0));
        setm(8'h0e, fr(2, 3, 4, 256, 3, 12, 0));
        setm(8'h4e, fr(2, 6, 8, 128, 3, 12, 0));
        setm(8'h0b, fr(4, 2, 1, 128, 1, 16, 0));
        setm(8'h19, fr(4, 3, 2, 256, 3, 12, 0));
        acc(1'b1, 16'h0702, 32'h0000000d, 4'h0);
        @(posedge clk);
        chk(frame_now, fr(4, 3, 2, 256, 3, 12, 0));
        foreach (bad[i]) begin
            acc(1'b1, 16'h0702, {24'h0, bad[i]}, 4'h1);
            @(posedge clk);
            chk(link_mode_unsupported, 1'b1);
        end
        acc(1'b0, 16'h0123, 32'h0, 4'hf);
        chk({q, resp}, {32'h0, 2'h2});
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, 16'h0670 + 16'(i), {31'h0, i < 4}, 4'h1);
            acc(1'b0, 16'h0670 + 16'(i), 32'h0, 4'hf);
            chk({q, lane_rate_sel[i]}, {31'h0, i < 4, 3'h0, i < 4});
        end
        foreach (rate[i]) begin
            acc(1'b1, 16'h0728, {24'h0, rate[i]}, 4'h1);
            chk(link_rate, rate[i]);
        end
        acc(1'b1, 16'h0780, 32'h1, 4'h1);
        chk(link_async_flag, 1'b1);
        acc(1'b1, 16'h00ca, 32'h20, 4'h1);
        chk(rate_ratio, 6'h20);
        man(1, 1, 2, 256, 1, 16, 1);
        man(1, 2, 4, 128, 1, 16, 0);
        man(1, 4, 8, 64, 1, 16, 0);
        man(1, 3, 8, 256, 3, 12, 0);
        give_verdict();
    end
endmodule
